//--- rtl/gld_regs.vh
// Register map, field layout and mode codes of the lookup decoder.
// Summary of operation
// R1: Upper-B mode 00 leaves pins 15..12 as plain GPIO.
// R2: Upper-B mode 01 drives pin 14 from two-input table B by pins 13..12.
// R3: Upper-B mode 10 drives pin 15 from three-input table B by pins 14..12.
// R4: Host writes reserved bits as zero and never selects upper mode 11.
// R5: Lower-B mode 00 leaves pins 11..8 as plain GPIO.
// R6: Lower-B mode 01 drives pin 10 from two-input table B by pins 9..8.
// R7: Lower-B mode 10 drives pin 11 from low three-input table B by pins 10..8.
// R8: Lower-B mode 11 drives pins 12 and 11 from dual tables B by pins 10..8.
// R9: Upper-A mode 00 leaves pins 7..4 as plain GPIO.
// R10: Upper-A mode 01 drives pin 6 from two-input table A by pins 5..4.
// R11: Upper-A mode 10 drives pin 7 from three-input table A by pins 6..4.
// R12: Lower-A mode 00 leaves pins 3..0 as plain GPIO.
// R13: Lower-A mode 01 drives pin 2 from two-input table A by pins 1..0.
// R14: Lower-A mode 10 drives pin 3 from low three-input table A by pins 2..0.
// R15: Lower-A mode 11 drives pins 4 and 3 from dual tables A by pins 2..0.
// R16: Two-input table B bits 7..4 map code on pins 13..12 to pin 14.
// R17: Two-input table B bits 3..0 map code on pins 9..8 to pin 10.
// R18: Two-input table A bits 7..4 map code on pins 5..4 to pin 6.
// R19: A table half matters only while its group selects the two-input decode.
// R20: Two-input table A bits 3..0 map code on pins 1..0 to pin 2.
// R21: Three-input table B bit n drives pin 15 when pins 14..12 equal n.
// R22: Three-input table A bit n drives pin 7 when pins 6..4 equal n.
// R23: Decoded pins follow their selecting pins combinationally.
// R24: Outside logic drives selecting pins only, never the decoded pins.
`ifndef GLD_REGS_VH
`define GLD_REGS_VH

`define GLD_ADDR_MODE_B       8'h20
`define GLD_ADDR_MODE_A       8'h21
`define GLD_ADDR_TWO_B        8'h22
`define GLD_ADDR_TWO_A        8'h23
`define GLD_ADDR_THREE_B      8'h24
`define GLD_ADDR_THREE_A      8'h25
`define GLD_ADDR_THREE_LOW_B  8'h26
`define GLD_ADDR_THREE_LOW_A  8'h27
`define GLD_ADDR_DUAL_FIRST_B 8'h28
`define GLD_ADDR_DUAL_SEC_B   8'h29
`define GLD_ADDR_DUAL_FIRST_A 8'h2a
`define GLD_ADDR_DUAL_SEC_A   8'h2b
`define GLD_ADDR_PIN_LO       8'h2c
`define GLD_ADDR_PIN_HI       8'h2d

`define GLD_REG_RESET         8'h00
`define GLD_READ_UNMAPPED     8'h00

`define GLD_HI_MSB            5
`define GLD_HI_LSB            4
`define GLD_LO_MSB            1
`define GLD_LO_LSB            0
`define GLD_HALF_HI_MSB       7
`define GLD_HALF_HI_LSB       4
`define GLD_HALF_LO_MSB       3
`define GLD_HALF_LO_LSB       0

`define GLD_PIN_CLEAR         16'h0000
`define GLD_BYTE_LO_MSB       7
`define GLD_BYTE_LO_LSB       0
`define GLD_BYTE_HI_MSB       15
`define GLD_BYTE_HI_LSB       8

`define GLD_UB_SEL2_MSB       13
`define GLD_UB_SEL3_MSB       14
`define GLD_UB_SEL_LSB        12
`define GLD_LB_SEL2_MSB       9
`define GLD_LB_SEL3_MSB       10
`define GLD_LB_SEL_LSB        8
`define GLD_UA_SEL2_MSB       5
`define GLD_UA_SEL3_MSB       6
`define GLD_UA_SEL_LSB        4
`define GLD_LA_SEL2_MSB       1
`define GLD_LA_SEL3_MSB       2
`define GLD_LA_SEL_LSB        0

`define GLD_UB_TWO_PIN        14
`define GLD_UB_THREE_PIN      15
`define GLD_LB_TWO_PIN        10
`define GLD_LB_THREE_PIN      11
`define GLD_LB_DUAL_HI_PIN    12
`define GLD_UA_TWO_PIN        6
`define GLD_UA_THREE_PIN      7
`define GLD_LA_TWO_PIN        2
`define GLD_LA_THREE_PIN      3
`define GLD_LA_DUAL_HI_PIN    4

`define GLD_MODE_GPIO         2'b00
`define GLD_MODE_TWO_TO_ONE   2'b01
`define GLD_MODE_THREE_TO_ONE 2'b10
`define GLD_MODE_THREE_TO_TWO 2'b11

`endif

//--- rtl/gld_lut8.v
// Eight-entry single-bit lookup cell.
`timescale 1ns/1ns
module gld_lut8 (
    input  wire [7:0] table_bits,
    input  wire [2:0] sel,
    output wire       result
);

    assign result = table_bits[sel];

endmodule // gld_lut8

//--- rtl/gld_lookup_decoder.v
// Lookup decoder of the GPIO expander with its table and mode registers.
`timescale 1ns/1ns
`include "gld_regs.vh"
module gld_lookup_decoder (
    input  wire        clk,
    input  wire        rst,
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_we,
    input  wire        reg_re,
    output reg  [7:0]  reg_rdata,
    output reg         reg_rvalid,
    input  wire [15:0] io_in,
    input  wire [15:0] gpio_data_out,
    input  wire [15:0] gpio_dir_out,
    output reg  [15:0] io_out,
    output reg  [15:0] io_oe,
    output wire [15:0] decode_active
);

    reg  [7:0]  logic_mode_bank_a;
    reg  [7:0]  logic_mode_bank_b;
    reg  [7:0]  two_input_table_bank_a;
    reg  [7:0]  two_input_table_bank_b;
    reg  [7:0]  three_input_table_bank_a;
    reg  [7:0]  three_input_table_bank_b;
    reg  [7:0]  three_input_table_low_a;
    reg  [7:0]  three_input_table_low_b;
    reg  [7:0]  dual_output_table_first_a;
    reg  [7:0]  dual_output_table_second_a;
    reg  [7:0]  dual_output_table_first_b;
    reg  [7:0]  dual_output_table_second_b;
    reg  [15:0] pin_meta;
    reg  [15:0] pin_sync;
    reg  [15:0] pin_sync_old;
    reg  [15:0] pin_level;
    reg  [7:0]  next_rdata;

    wire [1:0]  upper_b_group_mode;
    wire [1:0]  lower_b_group_mode;
    wire [1:0]  upper_a_group_mode;
    wire [1:0]  lower_a_group_mode;
    wire        lut_two_upper_b;
    wire        lut_two_lower_b;
    wire        lut_two_upper_a;
    wire        lut_two_lower_a;
    wire        lut_three_b;
    wire        lut_three_a;
    wire        lut_three_low_b;
    wire        lut_three_low_a;
    wire        lut_dual_first_b;
    wire        lut_dual_second_b;
    wire        lut_dual_first_a;
    wire        lut_dual_second_a;
    wire [1:0]  sel_two_upper_b;
    wire [1:0]  sel_two_lower_b;
    wire [1:0]  sel_two_upper_a;
    wire [1:0]  sel_two_lower_a;
    wire [2:0]  sel_three_upper_b;
    wire [2:0]  sel_three_lower_b;
    wire [2:0]  sel_three_upper_a;
    wire [2:0]  sel_three_lower_a;
    wire        wr_mode_a;
    wire        wr_mode_b;
    wire        wr_two_a;
    wire        wr_two_b;
    wire        wr_three_a;
    wire        wr_three_b;
    wire        wr_three_low_a;
    wire        wr_three_low_b;
    wire        wr_dual_first_a;
    wire        wr_dual_second_a;
    wire        wr_dual_first_b;
    wire        wr_dual_second_b;
    reg  [15:0] dec_mask;
    reg  [15:0] dec_value;

    // Mode fields of both banks.
    assign upper_b_group_mode = logic_mode_bank_b[`GLD_HI_MSB:`GLD_HI_LSB];
    assign lower_b_group_mode = logic_mode_bank_b[`GLD_LO_MSB:`GLD_LO_LSB];
    assign upper_a_group_mode = logic_mode_bank_a[`GLD_HI_MSB:`GLD_HI_LSB];
    assign lower_a_group_mode = logic_mode_bank_a[`GLD_LO_MSB:`GLD_LO_LSB];

    // Selecting pins of each group, taken straight from the pads.
    assign sel_two_upper_b   = io_in[`GLD_UB_SEL2_MSB:`GLD_UB_SEL_LSB];
    assign sel_two_lower_b   = io_in[`GLD_LB_SEL2_MSB:`GLD_LB_SEL_LSB];
    assign sel_two_upper_a   = io_in[`GLD_UA_SEL2_MSB:`GLD_UA_SEL_LSB];
    assign sel_two_lower_a   = io_in[`GLD_LA_SEL2_MSB:`GLD_LA_SEL_LSB];
    assign sel_three_upper_b = io_in[`GLD_UB_SEL3_MSB:`GLD_UB_SEL_LSB];
    assign sel_three_lower_b = io_in[`GLD_LB_SEL3_MSB:`GLD_LB_SEL_LSB];
    assign sel_three_upper_a = io_in[`GLD_UA_SEL3_MSB:`GLD_UA_SEL_LSB];
    assign sel_three_lower_a = io_in[`GLD_LA_SEL3_MSB:`GLD_LA_SEL_LSB];

    // One write strobe per mode and table register, so the pin level and unmapped addresses write nothing.
    assign wr_mode_a        = reg_we & (reg_addr == `GLD_ADDR_MODE_A);
    assign wr_mode_b        = reg_we & (reg_addr == `GLD_ADDR_MODE_B);
    assign wr_two_a         = reg_we & (reg_addr == `GLD_ADDR_TWO_A);
    assign wr_two_b         = reg_we & (reg_addr == `GLD_ADDR_TWO_B);
    assign wr_three_a       = reg_we & (reg_addr == `GLD_ADDR_THREE_A);
    assign wr_three_b       = reg_we & (reg_addr == `GLD_ADDR_THREE_B);
    assign wr_three_low_a   = reg_we & (reg_addr == `GLD_ADDR_THREE_LOW_A);
    assign wr_three_low_b   = reg_we & (reg_addr == `GLD_ADDR_THREE_LOW_B);
    assign wr_dual_first_a  = reg_we & (reg_addr == `GLD_ADDR_DUAL_FIRST_A);
    assign wr_dual_second_a = reg_we & (reg_addr == `GLD_ADDR_DUAL_SEC_A);
    assign wr_dual_first_b  = reg_we & (reg_addr == `GLD_ADDR_DUAL_FIRST_B);
    assign wr_dual_second_b = reg_we & (reg_addr == `GLD_ADDR_DUAL_SEC_B);

    // Register writes.
    always @(posedge clk) begin
        if (rst) begin
            logic_mode_bank_a          <= `GLD_REG_RESET;
            logic_mode_bank_b          <= `GLD_REG_RESET;
            two_input_table_bank_a     <= `GLD_REG_RESET;
            two_input_table_bank_b     <= `GLD_REG_RESET;
            three_input_table_bank_a   <= `GLD_REG_RESET;
            three_input_table_bank_b   <= `GLD_REG_RESET;
            three_input_table_low_a    <= `GLD_REG_RESET;
            three_input_table_low_b    <= `GLD_REG_RESET;
            dual_output_table_first_a  <= `GLD_REG_RESET;
            dual_output_table_second_a <= `GLD_REG_RESET;
            dual_output_table_first_b  <= `GLD_REG_RESET;
            dual_output_table_second_b <= `GLD_REG_RESET;
        end else begin
            if (wr_mode_a) begin
                logic_mode_bank_a <= reg_wdata;
            end
            if (wr_mode_b) begin
                logic_mode_bank_b <= reg_wdata;
            end
            if (wr_two_a) begin
                two_input_table_bank_a <= reg_wdata;
            end
            if (wr_two_b) begin
                two_input_table_bank_b <= reg_wdata;
            end
            if (wr_three_a) begin
                three_input_table_bank_a <= reg_wdata;
            end
            if (wr_three_b) begin
                three_input_table_bank_b <= reg_wdata;
            end
            if (wr_three_low_a) begin
                three_input_table_low_a <= reg_wdata;
            end
            if (wr_three_low_b) begin
                three_input_table_low_b <= reg_wdata;
            end
            if (wr_dual_first_a) begin
                dual_output_table_first_a <= reg_wdata;
            end
            if (wr_dual_second_a) begin
                dual_output_table_second_a <= reg_wdata;
            end
            if (wr_dual_first_b) begin
                dual_output_table_first_b <= reg_wdata;
            end
            if (wr_dual_second_b) begin
                dual_output_table_second_b <= reg_wdata;
            end
        end
    end

    // Pin levels pass four flip-flops before they are reported to software.
    always @(posedge clk) begin
        if (rst) begin
            pin_meta     <= `GLD_PIN_CLEAR;
            pin_sync     <= `GLD_PIN_CLEAR;
            pin_sync_old <= `GLD_PIN_CLEAR;
            pin_level    <= `GLD_PIN_CLEAR;
        end else begin
            pin_meta     <= io_in;
            pin_sync     <= pin_meta;
            pin_sync_old <= pin_sync;
            pin_level    <= (pin_sync & pin_sync_old) | (pin_level & (pin_sync | pin_sync_old));
        end
    end

    // Read data for the addressed register.
    always @* begin
        case (reg_addr)
            `GLD_ADDR_MODE_A:       next_rdata = logic_mode_bank_a;
            `GLD_ADDR_MODE_B:       next_rdata = logic_mode_bank_b;
            `GLD_ADDR_TWO_A:        next_rdata = two_input_table_bank_a;
            `GLD_ADDR_TWO_B:        next_rdata = two_input_table_bank_b;
            `GLD_ADDR_THREE_A:      next_rdata = three_input_table_bank_a;
            `GLD_ADDR_THREE_B:      next_rdata = three_input_table_bank_b;
            `GLD_ADDR_THREE_LOW_A:  next_rdata = three_input_table_low_a;
            `GLD_ADDR_THREE_LOW_B:  next_rdata = three_input_table_low_b;
            `GLD_ADDR_DUAL_FIRST_A: next_rdata = dual_output_table_first_a;
            `GLD_ADDR_DUAL_SEC_A:   next_rdata = dual_output_table_second_a;
            `GLD_ADDR_DUAL_FIRST_B: next_rdata = dual_output_table_first_b;
            `GLD_ADDR_DUAL_SEC_B:   next_rdata = dual_output_table_second_b;
            `GLD_ADDR_PIN_LO:       next_rdata = pin_level[`GLD_BYTE_LO_MSB:`GLD_BYTE_LO_LSB];
            `GLD_ADDR_PIN_HI:       next_rdata = pin_level[`GLD_BYTE_HI_MSB:`GLD_BYTE_HI_LSB];
            default:                next_rdata = `GLD_READ_UNMAPPED;
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            reg_rdata  <= `GLD_READ_UNMAPPED;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_re;
            if (reg_re) begin
                reg_rdata <= next_rdata;
            end
        end
    end

    // Two-input decodes use one half of a table each.
    gld_lut8 u_two_upper_b (
        .table_bits ({4'h0, two_input_table_bank_b[`GLD_HALF_HI_MSB:`GLD_HALF_HI_LSB]}), // R16
        .sel        ({1'b0, sel_two_upper_b}),
        .result     (lut_two_upper_b)
    );

    gld_lut8 u_two_lower_b (
        .table_bits ({4'h0, two_input_table_bank_b[`GLD_HALF_LO_MSB:`GLD_HALF_LO_LSB]}), // R17
        .sel        ({1'b0, sel_two_lower_b}),
        .result     (lut_two_lower_b)
    );

    gld_lut8 u_two_upper_a (
        .table_bits ({4'h0, two_input_table_bank_a[`GLD_HALF_HI_MSB:`GLD_HALF_HI_LSB]}), // R18
        .sel        ({1'b0, sel_two_upper_a}),
        .result     (lut_two_upper_a)
    );

    gld_lut8 u_two_lower_a (
        .table_bits ({4'h0, two_input_table_bank_a[`GLD_HALF_LO_MSB:`GLD_HALF_LO_LSB]}), // R20
        .sel        ({1'b0, sel_two_lower_a}),
        .result     (lut_two_lower_a)
    );

    // Three-input decodes.
    gld_lut8 u_three_b (
        .table_bits (three_input_table_bank_b), // R21
        .sel        (sel_three_upper_b),
        .result     (lut_three_b)
    );

    gld_lut8 u_three_a (
        .table_bits (three_input_table_bank_a), // R22
        .sel        (sel_three_upper_a),
        .result     (lut_three_a)
    );

    gld_lut8 u_three_low_b (
        .table_bits (three_input_table_low_b),
        .sel        (sel_three_lower_b),
        .result     (lut_three_low_b)
    );

    gld_lut8 u_three_low_a (
        .table_bits (three_input_table_low_a),
        .sel        (sel_three_lower_a),
        .result     (lut_three_low_a)
    );

    // Dual-output decodes.
    gld_lut8 u_dual_first_b (
        .table_bits (dual_output_table_first_b),
        .sel        (sel_three_lower_b),
        .result     (lut_dual_first_b)
    );

    gld_lut8 u_dual_second_b (
        .table_bits (dual_output_table_second_b),
        .sel        (sel_three_lower_b),
        .result     (lut_dual_second_b)
    );

    gld_lut8 u_dual_first_a (
        .table_bits (dual_output_table_first_a),
        .sel        (sel_three_lower_a),
        .result     (lut_dual_first_a)
    );

    gld_lut8 u_dual_second_a (
        .table_bits (dual_output_table_second_a),
        .sel        (sel_three_lower_a),
        .result     (lut_dual_second_a)
    );

    // Pins taken over by the decoders and the values they carry.
    always @* begin
        dec_mask  = `GLD_PIN_CLEAR;
        dec_value = `GLD_PIN_CLEAR;
        case (upper_b_group_mode)
            `GLD_MODE_TWO_TO_ONE: begin
                dec_mask[`GLD_UB_TWO_PIN]  = 1'b1; // R2
                dec_value[`GLD_UB_TWO_PIN] = lut_two_upper_b; // R19
            end
            `GLD_MODE_THREE_TO_ONE: begin
                dec_mask[`GLD_UB_THREE_PIN]  = 1'b1; // R3
                dec_value[`GLD_UB_THREE_PIN] = lut_three_b;
            end
            default: begin
            end // R1
        endcase
        case (upper_a_group_mode)
            `GLD_MODE_TWO_TO_ONE: begin
                dec_mask[`GLD_UA_TWO_PIN]  = 1'b1; // R10
                dec_value[`GLD_UA_TWO_PIN] = lut_two_upper_a; // R19
            end
            `GLD_MODE_THREE_TO_ONE: begin
                dec_mask[`GLD_UA_THREE_PIN]  = 1'b1; // R11
                dec_value[`GLD_UA_THREE_PIN] = lut_three_a;
            end
            default: begin
            end // R9
        endcase
        case (lower_b_group_mode)
            `GLD_MODE_TWO_TO_ONE: begin
                dec_mask[`GLD_LB_TWO_PIN]  = 1'b1; // R6
                dec_value[`GLD_LB_TWO_PIN] = lut_two_lower_b; // R19
            end
            `GLD_MODE_THREE_TO_ONE: begin
                dec_mask[`GLD_LB_THREE_PIN]  = 1'b1; // R7
                dec_value[`GLD_LB_THREE_PIN] = lut_three_low_b;
            end
            `GLD_MODE_THREE_TO_TWO: begin
                dec_mask[`GLD_LB_THREE_PIN]    = 1'b1; // R8
                dec_mask[`GLD_LB_DUAL_HI_PIN]  = 1'b1;
                dec_value[`GLD_LB_THREE_PIN]   = lut_dual_first_b;
                dec_value[`GLD_LB_DUAL_HI_PIN] = lut_dual_second_b;
            end
            default: begin
            end // R5
        endcase
        case (lower_a_group_mode)
            `GLD_MODE_TWO_TO_ONE: begin
                dec_mask[`GLD_LA_TWO_PIN]  = 1'b1; // R13
                dec_value[`GLD_LA_TWO_PIN] = lut_two_lower_a; // R19
            end
            `GLD_MODE_THREE_TO_ONE: begin
                dec_mask[`GLD_LA_THREE_PIN]  = 1'b1; // R14
                dec_value[`GLD_LA_THREE_PIN] = lut_three_low_a;
            end
            `GLD_MODE_THREE_TO_TWO: begin
                dec_mask[`GLD_LA_THREE_PIN]    = 1'b1; // R15
                dec_mask[`GLD_LA_DUAL_HI_PIN]  = 1'b1;
                dec_value[`GLD_LA_THREE_PIN]   = lut_dual_first_a;
                dec_value[`GLD_LA_DUAL_HI_PIN] = lut_dual_second_a;
            end
            default: begin
            end // R12
        endcase
    end

    assign decode_active = dec_mask;

    // Decoded pins override the GPIO data and direction without any clock edge.
    always @* begin
        io_out = (gpio_data_out & ~dec_mask) | (dec_value & dec_mask); // R23
        io_oe  = gpio_dir_out | dec_mask; // R23
    end

endmodule // gld_lookup_decoder

//--- verif/gld_checker.sv
// Checker of the lookup decoder port behaviour.
`timescale 1ns/1ns
module gld_checker (
    input wire        clk,
    input wire        rst,
    input wire [7:0]  reg_addr,
    input wire [7:0]  reg_wdata,
    input wire        reg_we,
    input wire        reg_re,
    input wire [7:0]  reg_rdata,
    input wire        reg_rvalid,
    input wire [15:0] io_in,
    input wire [15:0] gpio_data_out,
    input wire [15:0] gpio_dir_out,
    input wire [15:0] io_out,
    input wire [15:0] io_oe,
    input wire [15:0] decode_active
);
    wire [15:0] da = decode_active;
    wire [7:0]  wd = reg_wdata;
    wire        wb = reg_we && reg_addr == 8'h20;
    wire        wa = reg_we && reg_addr == 8'h21;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_gp; ((io_out ^ gpio_data_out) & ~da) == 16'h0000; endproperty
    a_gp: assert property (p_gp) else $error("plain pin value");
    property p_oe; ((io_oe ^ gpio_dir_out) & ~da | da & ~io_oe) == 16'h0000; endproperty
    a_oe: assert property (p_oe) else $error("pin enable");
    property p_b1; wb && wd[5:4] == 2'b01 |=> da[15:14] == 2'b01; endproperty
    a_b1: assert property (p_b1) else $error("upper b two input");
    property p_b2; wb && wd[5:4] == 2'b10 |=> da[15:14] == 2'b10; endproperty
    a_b2: assert property (p_b2) else $error("upper b three input");
    property p_c1; wb && wd[1:0] == 2'b01 |=> da[12:8] == 5'b00100; endproperty
    a_c1: assert property (p_c1) else $error("lower b two input");
    property p_c3; wb && wd[1:0] == 2'b11 |=> da[12:8] == 5'b11000; endproperty
    a_c3: assert property (p_c3) else $error("lower b dual output");
    property p_a1; wa && wd[1:0] == 2'b01 |=> da[4:0] == 5'b00100; endproperty
    a_a1: assert property (p_a1) else $error("lower a two input");
    property p_a3; wa && wd[1:0] == 2'b11 |=> da[4:0] == 5'b11000; endproperty
    a_a3: assert property (p_a3) else $error("lower a dual output");
endmodule  // gld_checker

bind gld_lookup_decoder gld_checker u_chk (.clk, .rst, .reg_addr, .reg_wdata, .reg_we, .reg_re,
    .reg_rdata, .reg_rvalid, .io_in, .gpio_data_out, .gpio_dir_out, .io_out, .io_oe,
    .decode_active);

//--- verif/gld_pin_model.sv
// Model of the outside logic that drives and reads the expander pins.
`timescale 1ns/1ns
module gld_pin_model (
    input  wire [15:0] io_out,
    input  wire [15:0] io_oe,
    input  wire [15:0] ext_level,
    output wire [15:0] io_in
);
    // Outside logic drives only the pins that the device leaves undriven.
    assign io_in = (io_out & io_oe) | (ext_level & ~io_oe);
endmodule  // gld_pin_model

//--- verif/gld_lookup_decoder_bench.sv
// Self-checking bench of the lookup decoder with random tables and pin levels.
`timescale 1ns/1ns
module gld_lookup_decoder_bench;
    reg         clk, rst, reg_we, reg_re;
    reg  [7:0]  reg_addr, reg_wdata;
    reg  [15:0] gpio_data_out, gpio_dir_out, ext;
    wire [7:0]  reg_rdata;
    wire        reg_rvalid;
    wire [15:0] io_in, io_out, io_oe, decode_active;
    reg  [7:0]  rv [0:11];
    reg  [47:0] e;
    integer     seed, fails, checks, cyc, n, a;

    gld_lookup_decoder u_dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata,
        .reg_rvalid, .io_in, .gpio_data_out, .gpio_dir_out, .io_out, .io_oe, .decode_active);
    gld_pin_model u_pins (.io_out, .io_oe, .ext_level(ext), .io_in);

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Expected pins as {levels, outputs, decoded}; four passes let chained groups settle.
    function [47:0] model(input [15:0] x);
        reg [15:0] o, d, l;
        integer k;
        begin
            l = x;
            for (k = 0; k < 4; k = k + 1) begin
                o = gpio_data_out;
                d = 16'h0000;
                case (rv[0][5:4])
                    2'b01: begin o[14] = rv[2][4 + l[13:12]]; d[14] = 1'b1; end
                    2'b10: begin o[15] = rv[4][l[14:12]]; d[15] = 1'b1; end
                endcase
                case (rv[0][1:0])
                    2'b01: begin o[10] = rv[2][l[9:8]]; d[10] = 1'b1; end
                    2'b10: begin o[11] = rv[6][l[10:8]]; d[11] = 1'b1; end
                    2'b11: begin o[12:11] = {rv[9][l[10:8]], rv[8][l[10:8]]}; d[12:11] = 2'b11; end
                endcase
                case (rv[1][5:4])
                    2'b01: begin o[6] = rv[3][4 + l[5:4]]; d[6] = 1'b1; end
                    2'b10: begin o[7] = rv[5][l[6:4]]; d[7] = 1'b1; end
                endcase
                case (rv[1][1:0])
                    2'b01: begin o[2] = rv[3][l[1:0]]; d[2] = 1'b1; end
                    2'b10: begin o[3] = rv[7][l[2:0]]; d[3] = 1'b1; end
                    2'b11: begin o[4:3] = {rv[11][l[2:0]], rv[10][l[2:0]]}; d[4:3] = 2'b11; end
                endcase
                l = (o & (d | gpio_dir_out)) | (x & ~(d | gpio_dir_out));
            end
            model = {l, o, d};
        end
    endfunction

    // Mode byte with reserved bits clear and no reserved upper code.
    function [7:0] md(input [7:0] r);
        md = {2'b00, r[5:4] == 2'b11 ? 2'b01 : r[5:4], 2'b00, r[1:0]};
    endfunction

    task cmp(input [63:0] nm, input [15:0] x, input [15:0] s);
        begin
            checks = checks + 1;
            if (s !== x) begin
                fails = fails + 1;
                $display("[ERR] %0s expected %h seen %h", nm, x, s);
            end
        end
    endtask

    task wr(input [7:0] ad, input [7:0] d);
        begin
            @(negedge clk);
            reg_addr = ad;
            reg_wdata = d;
            reg_we = 1'b1;
            @(negedge clk);
            reg_we = 1'b0;
        end
    endtask

    task rd(input [7:0] ad, input [7:0] x);
        begin
            @(negedge clk);
            reg_addr = ad;
            reg_re = 1'b1;
            @(negedge clk);
            reg_re = 1'b0;
            cmp("rvalid", 16'h0001, {15'h0000, reg_rvalid});
            cmp("rdata", {8'h00, x}, {8'h00, reg_rdata});
        end
    endtask

    // New outside levels, then the pins are compared with no clock edge between.
    task pins;
        begin
            @(negedge clk);
            ext = $random(seed);
            #1;
            e = model(ext);
            cmp("io_out", e[31:16], io_out);
            cmp("io_oe", e[15:0] | gpio_dir_out, io_oe);
            cmp("decoded", e[15:0], decode_active);
        end
    endtask

    task test_done;
        begin
            if (fails == 0 && checks > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask

    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 10000) begin
            fails = fails + 1;
            test_done;
        end
    end

    initial begin
        seed = 32'h7e1f3174;
        fails = 0;
        checks = 0;
        cyc = 0;
        rst = 1'b1;
        {reg_we, reg_re, reg_addr, reg_wdata, gpio_data_out, gpio_dir_out, ext} = 0;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        for (a = 0; a < 14; a = a + 1) rd(8'h20 + a, 8'h00);
        wr(8'h40, 8'hff);
        rd(8'h40, 8'h00);
        wr(8'h2c, 8'hff);
        rd(8'h2c, 8'h00);
        for (n = 0; n < 40; n = n + 1) begin
            for (a = 0; a < 12; a = a + 1) rv[a] = $random(seed);
            rv[0] = md(n < 4 ? {2'b00, n[1:0], 2'b00, n[1:0]} : rv[0]);
            rv[1] = md(n < 4 ? {2'b00, n[1:0], 2'b00, n[1:0]} : rv[1]);
            for (a = 0; a < 12; a = a + 1) wr(8'h20 + a, rv[a]);
            for (a = 0; a < 12; a = a + 1) rd(8'h20 + a, rv[a]);
            gpio_data_out = $random(seed);
            gpio_dir_out = $random(seed);
            pins;
            pins;
            repeat (5) @(negedge clk);
            rd(8'h2c, e[39:32]);
            rd(8'h2d, e[47:40]);
        end
        test_done;
    end
endmodule  // gld_lookup_decoder_bench
